// ===== design/ecs_pkg.sv
// Purpose: Shared types and constants for the execute-cycle sequencer.
// Assumes: 36-bit words split into two 18-bit halves.
// Notes:   Step numbers name the execute time pulses.
package ecs_pkg;
	localparam int WORD_W = 36;
	localparam int HALF_W = 18;
	localparam int STEP_W = 4;
	localparam logic [STEP_W-1:0] ET0  = 4'h0;
	localparam logic [STEP_W-1:0] ET1  = 4'h1;
	localparam logic [STEP_W-1:0] ET3  = 4'h3;
	localparam logic [STEP_W-1:0] ET4  = 4'h4;
	localparam logic [STEP_W-1:0] ET5  = 4'h5;
	localparam logic [STEP_W-1:0] ET6  = 4'h6;
	localparam logic [STEP_W-1:0] ET7  = 4'h7;
	localparam logic [STEP_W-1:0] ET9  = 4'h9;
	localparam logic [STEP_W-1:0] ET10 = 4'hA;

	typedef enum logic [2:0] {
		ECS_OP_HALF = 3'h0,
		ECS_OP_FULL = 3'h1,
		ECS_OP_MASKED_BIT_TEST = 3'h2,
		ECS_OP_JUMP_AND_RESTORE = 3'h3,
		ECS_OP_EXCHANGE_OP = 3'h4
	} ecs_op_t;

	typedef enum logic [1:0] {
		ECS_ACT_NONE = 2'h0,
		ECS_ACT_CLR  = 2'h1,
		ECS_ACT_COMP = 2'h2,
		ECS_ACT_SET  = 2'h3
	} ecs_act_t;

	typedef enum logic [1:0] {
		ECS_SK_NEVER = 2'h0,
		ECS_SK_ZERO  = 2'h1,
		ECS_SK_ALL   = 2'h2,
		ECS_SK_NONZ  = 2'h3
	} ecs_skip_t;

	typedef struct packed {
		ecs_op_t           op;
		logic              mode_mem;
		logic              mode_self;
		logic              src_ac;
		logic              store_e;
		logic              swap;
		logic              dest_left;
		logic              clear_other;
		logic              set_other;
		logic              negate;
		logic              magnitude;
		ecs_act_t          action;
		ecs_skip_t         skip_cond;
		logic              pc_inhibit;
		logic              pi_cycle;
		logic              console;
		logic              second_half;
		logic [HALF_W-1:0] jump_addr;
	} ecs_ctl_t;
endpackage : ecs_pkg

// ===== design/ecs_sequencer.sv
// Purpose: Execute-cycle pulse chain and register transfers.
// Assumes: Decoder holds ctl and operand words steady while start is high.
// Notes:   One execute pulse per clock; the step output names it.
`timescale 1ns/1ps

// Summary of operation
// RULE_01: Fetch end loads accumulator and memory words.
// RULE_02: Half transfer step zero: exchange or copy.
// RULE_03: Opposite-half transfer swaps buffer halves at one.
// RULE_04: Non-transfer half action clears register at one.
// RULE_05: Step four jams half, optionally sets other.
// RULE_06: Step ten copies result to buffer for storing.
// RULE_07: Exchange skips the final result copy.
// RULE_08: Full transfer step zero duplicates moved word.
// RULE_09: Full swapped transfer swaps buffer halves at one.
// RULE_10: Negation subroutine runs at step three.
// RULE_11: Move swapped exchanges registers at step four.
// RULE_12: Bit test step zero swaps mask halves.
// RULE_13: Step one forms test word, adjusts data.
// RULE_14: Step four swaps test and data words.
// RULE_15: Clear action: complement, zero-move, complement.
// RULE_16: Step nine tests skip, loads data word.
// RULE_17: Bit test writes accumulator only when changed.
// RULE_18: Jump restore: pulses five, six copy counter.
// RULE_19: Pulses nine, ten load address; no store.
// RULE_20: Counter increments at zero unless inhibited.
// RULE_21: Pulses six to nine skipped without second half.
// RULE_22: Carry flag cleared at every cycle start.
// RULE_23: Pulses ascend one at a time, except the jump from five to ten.
module ecs_sequencer
	import ecs_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	input  wire logic              start,
	input  wire ecs_ctl_t          ctl,
	input  wire logic [WORD_W-1:0] accumulator,
	input  wire logic [WORD_W-1:0] mem_word,
	input  wire logic [HALF_W-1:0] pc_in,
	output logic [WORD_W-1:0]      arith_register,
	output logic [WORD_W-1:0]      memory_buffer,
	output logic [HALF_W-1:0]      memory_address_register,
	output logic [HALF_W-1:0]      program_counter,
	output logic                   carry_out_flag,
	output logic [STEP_W-1:0]      execute_time_pulse,
	output logic                   busy,
	output logic                   done,
	output logic                   skip,
	output logic                   store_ac
);
	typedef enum logic [0:0] {
		ECS_IDLE = 1'b0,
		ECS_RUN  = 1'b1
	} ecs_state_t;

	ecs_state_t        state;
	ecs_ctl_t          c;
	logic [WORD_W-1:0] orig_data;
	logic [STEP_W-1:0] next_step;

	function automatic logic [WORD_W-1:0] swap_halves(input logic [WORD_W-1:0] w);
		swap_halves = {w[HALF_W-1:0], w[WORD_W-1:HALF_W]};
	endfunction : swap_halves

	// Second-half pulses are dropped by jumping straight from five to ten.
	always_comb begin
		if (execute_time_pulse == ET5 && !c.second_half)  // see RULE_21
			next_step = ET10;
		else
			next_step = execute_time_pulse + 4'h1;  // see RULE_23
	end

	assign busy = (state == ECS_RUN);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state              <= ECS_IDLE;
			execute_time_pulse <= ET0;
			done               <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				ECS_IDLE: begin
					if (start) begin
						state              <= ECS_RUN;
						execute_time_pulse <= ET0;
					end
				end
				ECS_RUN: begin
					if (execute_time_pulse == ET10) begin
						state <= ECS_IDLE;
						done  <= 1'b1;
					end else begin
						execute_time_pulse <= next_step;
					end
				end
				default: state <= ECS_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			c <= '0;
		else if (state == ECS_IDLE && start)
			c <= ctl;
	end

	// Register transfers, one group per execute pulse.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			arith_register <= '0;
			memory_buffer  <= '0;
			orig_data      <= '0;
		end else if (state == ECS_IDLE) begin
			if (start) begin
				arith_register <= accumulator;  // see RULE_01
				memory_buffer  <= mem_word;     // see RULE_01
				orig_data      <= accumulator;
			end
		end else begin
			case (c.op)
				ECS_OP_HALF: begin
					if (execute_time_pulse == ET0) begin
						if (c.mode_mem) begin  // see RULE_02
							memory_buffer  <= arith_register;
							arith_register <= memory_buffer;
						end else if (c.mode_self) begin
							arith_register <= memory_buffer;  // see RULE_02
						end
					end
					if (execute_time_pulse == ET1) begin
						if (c.swap)
							memory_buffer <= swap_halves(memory_buffer);  // see RULE_03
						if (c.clear_other || c.set_other)
							arith_register <= '0;  // see RULE_04
					end
					if (execute_time_pulse == ET4) begin
						if (c.dest_left)  // see RULE_05
							arith_register <= {memory_buffer[WORD_W-1:HALF_W],
								c.set_other ? {HALF_W{1'b1}} : arith_register[HALF_W-1:0]};
						else
							arith_register <= {
								c.set_other ? {HALF_W{1'b1}} : arith_register[WORD_W-1:HALF_W],
								memory_buffer[HALF_W-1:0]};
					end
					if (execute_time_pulse == ET10 && c.store_e)
						memory_buffer <= arith_register;  // see RULE_06
				end
				ECS_OP_FULL: begin
					if (execute_time_pulse == ET0) begin
						if (c.src_ac)
							memory_buffer <= arith_register;  // see RULE_08
						else
							arith_register <= memory_buffer;  // see RULE_08
					end
					if (execute_time_pulse == ET1 && c.swap)
						memory_buffer <= swap_halves(memory_buffer);  // see RULE_09
					if (execute_time_pulse == ET3 &&
						(c.negate || (c.magnitude && arith_register[WORD_W-1])))
						arith_register <= WORD_W'(-arith_register);  // see RULE_10
					// A one-way move would do, but only the two-way path exists.
					if (execute_time_pulse == ET4 && c.swap) begin
						memory_buffer  <= arith_register;  // see RULE_11
						arith_register <= memory_buffer;   // see RULE_11
					end
					if (execute_time_pulse == ET10 && c.store_e)
						memory_buffer <= arith_register;  // see RULE_06
				end
				ECS_OP_MASKED_BIT_TEST: begin
					if (execute_time_pulse == ET0 && c.swap)
						memory_buffer <= swap_halves(memory_buffer);  // see RULE_12
					if (execute_time_pulse == ET1) begin
						memory_buffer <= memory_buffer & arith_register;  // see RULE_13
						if (c.action == ECS_ACT_COMP)
							arith_register <= arith_register ^ memory_buffer;  // see RULE_13
						else if (c.action == ECS_ACT_SET)
							arith_register <= arith_register | memory_buffer;  // see RULE_13
					end
					if (execute_time_pulse == ET4) begin
						arith_register <= memory_buffer;   // see RULE_14
						memory_buffer  <= arith_register;  // see RULE_14
					end
					if (c.action == ECS_ACT_CLR) begin
						if (execute_time_pulse == ET5 || execute_time_pulse == ET7)
							arith_register <= ~arith_register;  // see RULE_15
						if (execute_time_pulse == ET6)
							memory_buffer <= memory_buffer & arith_register;  // see RULE_15
					end
					if (execute_time_pulse == ET9) begin
						arith_register <= memory_buffer;  // see RULE_16
						memory_buffer  <= arith_register;
					end
				end
				ECS_OP_JUMP_AND_RESTORE: begin
					if (execute_time_pulse == ET5 || execute_time_pulse == ET6)
						memory_buffer <= {{HALF_W{1'b0}}, program_counter};  // see RULE_18
				end
				ECS_OP_EXCHANGE_OP: begin
					if (execute_time_pulse == ET0) begin
						memory_buffer  <= arith_register;
						arith_register <= memory_buffer;
					end
					// Both words are already in place, so step ten does nothing. see RULE_07
				end
				default: ;
			endcase
		end
	end

	// Counter and address register.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			program_counter         <= '0;
			memory_address_register <= '0;
		end else if (state == ECS_IDLE) begin
			if (start)
				program_counter <= pc_in;
		end else begin
			if (execute_time_pulse == ET0 && !c.pc_inhibit && !c.pi_cycle && !c.console)
				program_counter <= program_counter + 18'h00001;  // see RULE_20
			if (c.op == ECS_OP_JUMP_AND_RESTORE) begin
				if (execute_time_pulse == ET7)
					program_counter <= c.jump_addr;
				if (execute_time_pulse == ET9 || execute_time_pulse == ET10)
					memory_address_register <= memory_buffer[HALF_W-1:0];  // see RULE_19
			end
		end
	end

	// Carry flag, skip result and the accumulator store gate.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			carry_out_flag <= 1'b0;
			skip           <= 1'b0;
			store_ac       <= 1'b0;
		end else if (state == ECS_IDLE) begin
			if (start) begin
				carry_out_flag <= 1'b0;  // see RULE_22
				skip           <= 1'b0;
				store_ac       <= 1'b0;
			end
		end else begin
			// Only a real negation of zero carries out; a zero magnitude is never negated.
			if (c.op == ECS_OP_FULL && execute_time_pulse == ET3 && arith_register == '0 &&
				(c.negate || (c.magnitude && arith_register[WORD_W-1])))
				carry_out_flag <= 1'b1;
			if (c.op == ECS_OP_MASKED_BIT_TEST && execute_time_pulse == ET9) begin
				case (c.skip_cond)  // see RULE_16
					ECS_SK_ZERO: skip <= (arith_register == '0);
					ECS_SK_ALL:  skip <= 1'b1;
					ECS_SK_NONZ: skip <= (arith_register != '0);
					default:     skip <= 1'b0;
				endcase
				store_ac <= (memory_buffer != orig_data);  // see RULE_17
			end
			// Jump and restore leaves the store gate low. see RULE_19
		end
	end

	a_step_order: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see RULE_23
		busy && $past(busy) && execute_time_pulse != ET0 |->
			execute_time_pulse > $past(execute_time_pulse))
		else $error("Execute pulses out of order.");

	a_second_skip: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see RULE_21
		busy && execute_time_pulse == ET5 && !c.second_half |=> execute_time_pulse == ET10)
		else $error("Second half not skipped.");

	a_fetch_load: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see RULE_01
		!busy && start |=> arith_register == $past(accumulator) &&
			memory_buffer == $past(mem_word))
		else $error("Fetch words not loaded.");

	a_carry_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see RULE_22
		!busy && start |=> !carry_out_flag && execute_time_pulse == ET0)
		else $error("Carry flag not cleared.");

	a_pc_incr: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see RULE_20
		busy && execute_time_pulse == ET0 && !c.pc_inhibit && !c.pi_cycle && !c.console
			|=> program_counter == $past(program_counter) + 18'h00001)
		else $error("Counter not incremented.");

	a_half_swap: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see RULE_03
		busy && execute_time_pulse == ET1 && c.op == ECS_OP_HALF && c.swap
			|=> memory_buffer == swap_halves($past(memory_buffer)))
		else $error("Half swap missing.");

	a_move_swapped_xchg: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see RULE_11
		busy && execute_time_pulse == ET4 && c.op == ECS_OP_FULL && c.swap
			|=> arith_register == $past(memory_buffer) &&
				memory_buffer == $past(arith_register))
		else $error("Swapped move exchange missing.");

	a_exchange_op_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see RULE_07
		busy && execute_time_pulse == ET10 && c.op == ECS_OP_EXCHANGE_OP
			|=> $stable(memory_buffer))
		else $error("Exchange result copied.");

	a_jump_and_restore_addr: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see RULE_19
		busy && execute_time_pulse == ET10 && c.op == ECS_OP_JUMP_AND_RESTORE
			|=> memory_address_register == $past(memory_buffer[HALF_W-1:0]) && !store_ac)
		else $error("Address register not loaded.");

	a_cycle_len: assert property (@(posedge sys_clk) disable iff (sys_rst)  // see RULE_23
		!busy && start && ctl.second_half |=> busy [*8] ##4 done)
		else $error("Full cycle length wrong.");
endmodule : ecs_sequencer

// ===== tb/execute_cycle_transfer_sequencer_tb.sv
// Purpose: Self-checking bench for the execute-cycle sequencer.
// Assumes: One instruction at a time; start is raised only while the block is idle.
// Notes:   Expected words are built here from the transfer rules, never read back.
`timescale 1ns/1ps
module execute_cycle_transfer_sequencer_tb
	import ecs_pkg::*;
;
	logic              sys_clk = 1'b0;
	logic              sys_rst = 1'b1;
	logic              start = 1'b0;
	ecs_ctl_t          ctl = '0;
	logic [WORD_W-1:0] accumulator = '0;
	logic [WORD_W-1:0] mem_word = '0;
	logic [HALF_W-1:0] pc_in = '0;
	logic [WORD_W-1:0] arith_register;
	logic [WORD_W-1:0] memory_buffer;
	logic [HALF_W-1:0] memory_address_register;
	logic [HALF_W-1:0] program_counter;
	logic [STEP_W-1:0] execute_time_pulse;
	logic              carry_out_flag;
	logic              busy;
	logic              done;
	logic              skip;
	logic              store_ac;
	int                bad_count = 0;
	int                check_count = 0;

	always #25 sys_clk = ~sys_clk;

	ecs_sequencer uut (.sys_clk, .sys_rst, .start, .ctl, .accumulator, .mem_word, .pc_in,
		.arith_register, .memory_buffer, .memory_address_register, .program_counter,
		.carry_out_flag, .execute_time_pulse, .busy, .done, .skip, .store_ac);

	task check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t ns: saw %h, expected %h", $time, got, exp);
		end
	endtask : check

	task end_of_test();
		$display("checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test

	function automatic ecs_ctl_t mk(input ecs_op_t op);
		ecs_ctl_t c;
		c = '0;
		c.op = op;
		return c;
	endfunction : mk

	// Issues one instruction and follows the pulse chain step by step until done.
	task automatic run(input ecs_ctl_t c, input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] m,
		input logic [HALF_W-1:0] p);
		int n;
		logic [STEP_W-1:0] exp;
		@(posedge sys_clk);
		ctl <= c;
		accumulator <= a;
		mem_word <= m;
		pc_in <= p;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		exp = ET0;
		n = 0;
		while (n < 40) begin
			#1;
			if (done === 1'b1) break;
			if (busy === 1'b1) begin
				check(WORD_W'(execute_time_pulse), WORD_W'(exp));
				exp = (exp == ET5 && !c.second_half) ? ET10 : exp + 4'h1;
			end
			@(posedge sys_clk);
			n++;
		end
		if (n >= 40) begin
			bad_count++;
			end_of_test();
		end
		check(WORD_W'(n), c.second_half ? 36'h00000000B : 36'h000000007);
	endtask : run

	task automatic t_half_mem();
		ecs_ctl_t c;
		c = mk(ECS_OP_HALF);
		c.mode_mem = 1'b1;
		c.swap = 1'b1;
		c.dest_left = 1'b1;
		c.store_e = 1'b1;
		run(c, {18'h0ABCD, 18'h12345}, {18'h2AAAA, 18'h15555}, 18'h00100);
		check(arith_register, {18'h12345, 18'h15555});
		check(memory_buffer, {18'h12345, 18'h15555});
		check(WORD_W'(program_counter), 36'h000000101);
	endtask : t_half_mem

	task automatic t_half_self();
		ecs_ctl_t c;
		for (int i = 0; i < 2; i++) begin
			c = mk(ECS_OP_HALF);
			c.mode_self = 1'b1;
			c.clear_other = 1'b1;
			c.set_other = i[0];
			c.store_e = 1'b1;
			run(c, 36'h123456789, {18'h0ABCD, 18'h12345}, 18'h00010);
			check(arith_register, {i[0] ? 18'h3FFFF : 18'h00000, 18'h12345});
			check(memory_buffer, {i[0] ? 18'h3FFFF : 18'h00000, 18'h12345});
		end
	endtask : t_half_self

	task automatic t_exchange_op_full();
		ecs_ctl_t c;
		run(mk(ECS_OP_EXCHANGE_OP), 36'h111122223, 36'h444455556, 18'h00020);
		check(arith_register, 36'h444455556);
		check(memory_buffer, 36'h111122223);
		c = mk(ECS_OP_FULL);
		c.src_ac = 1'b1;
		run(c, 36'h0000ABCDE, 36'h777777777, 18'h00030);
		check(arith_register, 36'h0000ABCDE);
		check(memory_buffer, 36'h0000ABCDE);
		c = mk(ECS_OP_FULL);
		c.swap = 1'b1;
		run(c, 36'h0, {18'h01111, 18'h02222}, 18'h00040);
		check(arith_register, {18'h02222, 18'h01111});
		check(memory_buffer, {18'h01111, 18'h02222});
	endtask : t_exchange_op_full

	task automatic t_negate();
		ecs_ctl_t c;
		c = mk(ECS_OP_FULL);
		c.negate = 1'b1;
		run(c, 36'h5, 36'h0, 18'h00050);
		check(arith_register, 36'h0);
		check(WORD_W'(carry_out_flag), 36'h1);
		c = mk(ECS_OP_FULL);
		c.magnitude = 1'b1;
		run(c, 36'h0, 36'hFFFFFFFFB, 18'h00060);
		check(arith_register, 36'h000000005);
		check(WORD_W'(carry_out_flag), 36'h0);
		c = mk(ECS_OP_FULL);
		c.magnitude = 1'b1;
		run(c, 36'h0, 36'h0, 18'h00068);
		check(arith_register, 36'h0);
		check(WORD_W'(carry_out_flag), 36'h0);
	endtask : t_negate

	task automatic t_pc_gates();
		ecs_ctl_t c;
		for (int g = 0; g < 3; g++) begin
			c = mk(ECS_OP_HALF);
			c.pc_inhibit = (g == 0);
			c.pi_cycle = (g == 1);
			c.console = (g == 2);
			run(c, 36'h0, 36'h0, 18'h00777);
			check(WORD_W'(program_counter), 36'h000000777);
		end
	endtask : t_pc_gates

	// Set leaves the data unchanged here, so the write-back flag must stay low for it.
	task automatic t_bit_test();
		ecs_ctl_t c;
		logic [WORD_W-1:0] d, m, e;
		d = {18'h3FFFF, 18'h00F0F};
		m = {18'h00F0F, 18'h00000};
		for (int i = 0; i < 4; i++) begin
			c = mk(ECS_OP_MASKED_BIT_TEST);
			c.second_half = 1'b1;
			c.action = ecs_act_t'(i);
			c.skip_cond = ecs_skip_t'(i);
			run(c, d, m, 18'h00070);
			e = (i == 1) ? (d & ~m) : (i == 2) ? (d ^ m) : (i == 3) ? (d | m) : d;
			check(arith_register, e);
			check(memory_buffer, d & m);
			check(WORD_W'(skip), WORD_W'(i >= 2));
			check(WORD_W'(store_ac), WORD_W'(e !== d));
		end
		c = mk(ECS_OP_MASKED_BIT_TEST);
		c.second_half = 1'b1;
		c.swap = 1'b1;
		c.skip_cond = ECS_SK_ZERO;
		run(c, {18'h3FFFF, 18'h00000}, {18'h00000, 18'h3FFFF}, 18'h00070);
		check(memory_buffer, {18'h3FFFF, 18'h00000});
		check(WORD_W'(skip), 36'h0);
	endtask : t_bit_test

	task automatic t_jump();
		ecs_ctl_t c;
		c = mk(ECS_OP_JUMP_AND_RESTORE);
		c.second_half = 1'b1;
		c.jump_addr = 18'h01234;
		run(c, 36'h0, 36'h0, 18'h00200);
		check(WORD_W'(memory_address_register), 36'h000000201);
		check(WORD_W'(program_counter), 36'h000001234);
	endtask : t_jump

	initial begin
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1;
		check(arith_register, 36'h0);
		check(WORD_W'(busy), 36'h0);
		t_half_mem();
		t_half_self();
		t_exchange_op_full();
		t_negate();
		t_pc_gates();
		t_bit_test();
		t_jump();
		end_of_test();
	end
endmodule : execute_cycle_transfer_sequencer_tb
